// ==== include/sbd_pkg.sv ====
// constants for the front-panel sync bus input and delay block
// assumes a single 250 MHz clock shared by the register bus and the sync logic
package sbd_pkg;
   // register bus
   localparam int unsigned ADDR_W = 6;
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_TAP0 = 6'h04;
   localparam logic [5:0] OFS_TAP1 = 6'h08;
   localparam logic [5:0] OFS_TAP2 = 6'h0C;
   localparam logic [5:0] OFS_TAP3 = 6'h10;
   localparam logic [5:0] OFS_TAP4 = 6'h14;
   localparam logic [5:0] OFS_STATUS = 6'h18;
   localparam logic [5:0] OFS_CONFIG = 6'h1C;
   localparam logic [3:0] IDX_NONE = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // control register fields
   localparam int unsigned CTRL_W = 15;
   localparam logic [14:0] CTRL_RESET = 15'h0000;
   localparam int unsigned CTRL_MASTER = 0;
   localparam int unsigned CTRL_SW_GATE = 1;
   localparam int unsigned CTRL_SW_SYNC = 2;
   localparam int unsigned CTRL_SW_PPS = 3;
   localparam int unsigned CTRL_OGATE_LSB = 4;
   localparam int unsigned CTRL_OSYNC_LSB = 6;
   localparam int unsigned CTRL_EGATE_LSB = 8;
   localparam int unsigned CTRL_ESYNC_LSB = 10;
   localparam int unsigned CTRL_EPPS_LSB = 12;
   // input paths
   localparam int unsigned NUM_PATHS = 5;
   localparam int unsigned NUM_INT_PATHS = 4;
   localparam int unsigned P_DGATE = 0;
   localparam int unsigned P_DSYNC = 1;
   localparam int unsigned P_TGATE = 2;
   localparam int unsigned P_TSYNC = 3;
   localparam int unsigned P_CGATE = 4;
   localparam int unsigned TAP_W = 9;
   localparam int unsigned TAP_MAX = 511;
   localparam int unsigned INT_DLY_MAX = 3;
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned CLK_MHZ = 250;
endpackage

// ==== design/sbd_pin_sync.sv ====
// three-flop synchroniser for one front-panel pin
// assumes the pin is asynchronous to aclk; output moves once stages 1 and 2 agree
`timescale 1ns/100ps
module sbd_pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_in,
   output logic level_out
);
   typedef struct packed {
      logic [sbd_pkg::SYNC_STAGES-1:0] stg;
      logic lvl;
   } sbd_sync_state_t;
   sbd_sync_state_t s_q, s_d;

   // stage 0 only feeds stage 1, never the agreement test
   always_comb begin
      s_d = s_q;
      s_d.stg = {s_q.stg[1:0], pin_in};
      if (s_q.stg[1] == s_q.stg[2]) begin
         s_d.lvl = s_q.stg[2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_out = s_q.lvl;
endmodule // sbd_pin_sync

// ==== design/sbd_cycle_delay.sv ====
// whole-cycle delay: register chain with a tap chosen at reset
// assumes input already on aclk; tap select latched from a build value
`timescale 1ns/100ps
module sbd_cycle_delay #(
   parameter logic [1:0] INIT_DELAY = 2'h0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sig_in,
   output logic sig_out
);
   typedef struct packed {
      logic [sbd_pkg::INT_DLY_MAX-1:0] chain;
      logic [1:0] sel;
   } sbd_dly_state_t;
   sbd_dly_state_t s_q, s_d;

   // select is frozen at its reset value; no software path changes it
   always_comb begin
      s_d = s_q;
      s_d.chain = {s_q.chain[1:0], sig_in};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q.chain <= '0;
         s_q.sel <= INIT_DELAY;
      end else begin
         s_q <= s_d;
      end
   end

   // tap 0 passes straight through, others pick a chain stage
   always_comb begin
      if (s_q.sel == 2'h0) begin
         sig_out = sig_in;
      end else begin
         sig_out = s_q.chain[s_q.sel - 2'h1];
      end
   end
endmodule // sbd_cycle_delay

// ==== design/sbd_top.sv ====
// sync bus input delay, outgoing line sourcing and relay top level
// assumes aclk is both sample and register clock; tap values drive delay cells
// outside, whole-cycle delays are built here from flip-flops
`timescale 1ns/100ps
module sbd_top #(
   parameter bit relay_master_option = 1'b0,
   parameter bit gate_relay_output_present = 1'b0,
   parameter bit sync_relay_output_present = 1'b0,
   parameter bit coax_relay_output_present = 1'b0,
   parameter bit has_coax_gate_input = 1'b0,
   parameter bit has_user_pps_input = 1'b0,
   parameter bit has_user_sync_drive = 1'b0,
   parameter bit has_user_gate_drive = 1'b0,
   parameter logic [8:0] init_dgate_tap = 9'h000,
   parameter logic [8:0] init_dsync_tap = 9'h000,
   parameter logic [8:0] init_tgate_tap = 9'h000,
   parameter logic [8:0] init_tsync_tap = 9'h000,
   parameter logic [8:0] init_cgate_tap = 9'h000,
   parameter logic [1:0] init_dgate_int = 2'h0,
   parameter logic [1:0] init_dsync_int = 2'h0,
   parameter logic [1:0] init_tgate_int = 2'h0,
   parameter logic [1:0] init_tsync_int = 2'h0
) (
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [5:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // front-panel inputs, after the external delay cells
   input wire logic diff_gate_in,
   input wire logic diff_sync_in,
   input wire logic ttl_gate_in,
   input wire logic ttl_sync_in,
   input wire logic coax_gate_in,
   // user-design inputs on aclk
   input wire logic user_pps_in,
   input wire logic user_sync_drive_in,
   input wire logic user_gate_drive_in,
   // front-panel outputs
   output logic bus_master_en,
   output logic diff_gate_out,
   output logic diff_sync_out,
   output logic gate_relay_out,
   output logic sync_relay_out,
   output logic coax_relay_out,
   // tap settings for the external delay cells
   output logic [8:0] dgate_tap,
   output logic [8:0] dsync_tap,
   output logic [8:0] tgate_tap,
   output logic [8:0] tsync_tap,
   output logic [8:0] cgate_tap,
   // selected timing levels for event generation
   output logic evt_gate,
   output logic evt_sync,
   output logic evt_pps
);
   localparam int unsigned NP = sbd_pkg::NUM_PATHS;
   localparam logic [8:0] TAP_INIT [NP] = '{init_dgate_tap, init_dsync_tap,
      init_tgate_tap, init_tsync_tap, init_cgate_tap};
   localparam logic [1:0] INT_INIT [sbd_pkg::NUM_INT_PATHS] = '{init_dgate_int,
      init_dsync_int, init_tgate_int, init_tsync_int};

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [5:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [14:0] ctrl;
      logic [NP-1:0][8:0] tap;
      logic master;
      logic gate_out;
      logic sync_out;
      logic gate_relay;
      logic sync_relay;
      logic coax_relay;
      logic evt_gate;
      logic evt_sync;
      logic evt_pps;
      logic gate_prev;
   } sbd_top_state_t;
   sbd_top_state_t s_q, s_d;

   logic [NP-1:0] sync_lvl;
   logic [NP-1:0] dly_lvl;

   // address to register index; shared by write and read decode
   function automatic logic [3:0] reg_index(input logic [5:0] a);
      logic [5:0] w;
      w = {a[5:2], 2'b00};
      unique case (w)
         sbd_pkg::OFS_CTRL: reg_index = 4'h0;
         sbd_pkg::OFS_TAP0: reg_index = 4'h1;
         sbd_pkg::OFS_TAP1: reg_index = 4'h2;
         sbd_pkg::OFS_TAP2: reg_index = 4'h3;
         sbd_pkg::OFS_TAP3: reg_index = 4'h4;
         sbd_pkg::OFS_TAP4: reg_index = 4'h5;
         sbd_pkg::OFS_STATUS: reg_index = 4'h6;
         sbd_pkg::OFS_CONFIG: reg_index = 4'h7;
         default: reg_index = sbd_pkg::IDX_NONE;
      endcase
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction

   // synchronise every present pin (coax gate tied low when absent), then delay the four bus inputs by whole cycles
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_path
         logic pin;
         assign pin = (gi == sbd_pkg::P_DGATE) ? diff_gate_in :
                      (gi == sbd_pkg::P_DSYNC) ? diff_sync_in :
                      (gi == sbd_pkg::P_TGATE) ? ttl_gate_in :
                      (gi == sbd_pkg::P_TSYNC) ? ttl_sync_in : coax_gate_in;
         if (gi == sbd_pkg::P_CGATE && !has_coax_gate_input) begin : g_absent
            assign sync_lvl[gi] = 1'b0;
            assign dly_lvl[gi] = 1'b0;
         end else begin : g_present
            sbd_pin_sync u_sync (
               .aclk(aclk),
               .aresetn(aresetn),
               .pin_in(pin),
               .level_out(sync_lvl[gi])
            );
            if (gi < sbd_pkg::NUM_INT_PATHS) begin : g_int
               sbd_cycle_delay #(.INIT_DELAY(INT_INIT[gi])) u_dly (
                  .aclk(aclk),
                  .aresetn(aresetn),
                  .sig_in(sync_lvl[gi]),
                  .sig_out(dly_lvl[gi])
               );
            end else begin : g_noint
               assign dly_lvl[gi] = sync_lvl[gi];
            end
         end
      end
   endgenerate

   // optional user sources read as zero when their option is off
   logic upps;
   logic usync;
   logic ugate;
   assign upps = has_user_pps_input ? user_pps_in : 1'b0;
   assign usync = has_user_sync_drive ? user_sync_drive_in : 1'b0;
   assign ugate = has_user_gate_drive ? user_gate_drive_in : 1'b0;

   // next state: bus slave, registers and source selection
   always_comb begin
      logic [3:0] widx;
      logic [3:0] ridx;
      logic [31:0] word;
      logic gate_edge;
      s_d = s_q;
      widx = reg_index(s_q.awaddr);
      ridx = reg_index(s_axi_araddr);
      word = 32'h0000_0000;
      gate_edge = s_q.evt_gate ^ s_q.gate_prev;

      // write address and data are taken separately, in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.awaddr = s_axi_awaddr;
         s_d.aw_held = 1'b1;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
         s_d.w_held = 1'b1;
      end
      s_d.awready = !s_d.aw_held && !s_q.bvalid;
      s_d.wready = !s_d.w_held && !s_q.bvalid;

      // commit once both halves are held; response stands until bready
      if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = sbd_pkg::RESP_OKAY;
         if (widx == 4'h0) begin
            word = merge({17'h0_0000, s_q.ctrl}, s_q.wdata, s_q.wstrb);
            s_d.ctrl = word[sbd_pkg::CTRL_W-1:0];
         end else if (widx >= 4'h1 && widx <= 4'h5) begin
            word = merge({23'h00_0000, s_q.tap[widx - 4'h1]}, s_q.wdata, s_q.wstrb);
            s_d.tap[widx - 4'h1] = word[sbd_pkg::TAP_W-1:0];
         end else if (widx == sbd_pkg::IDX_NONE) begin
            s_d.bresp = sbd_pkg::RESP_SLVERR;
         end
      end else if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
         s_d.awready = !s_d.aw_held;
         s_d.wready = !s_d.w_held;
      end

      // read: one outstanding, data captured when the address is taken
      if (s_axi_arvalid && s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rvalid = 1'b1;
         s_d.rresp = sbd_pkg::RESP_OKAY;
         unique case (ridx)
            4'h0: s_d.rdata = {17'h0_0000, s_q.ctrl};
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5: s_d.rdata = {23'h00_0000, s_q.tap[ridx - 4'h1]};
            4'h6: s_d.rdata = {23'h00_0000, s_q.evt_pps, s_q.evt_sync, s_q.evt_gate,
               s_q.master, dly_lvl};
            4'h7: s_d.rdata = {24'h00_0000, has_user_gate_drive, has_user_sync_drive,
               has_user_pps_input, has_coax_gate_input, coax_relay_output_present,
               sync_relay_output_present, gate_relay_output_present,
               relay_master_option};
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = sbd_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
         s_d.arready = 1'b1;
      end

      // outgoing differential gate source
      unique case (s_q.ctrl[sbd_pkg::CTRL_OGATE_LSB +: 2])
         2'h0: s_d.gate_out = s_q.ctrl[sbd_pkg::CTRL_SW_GATE];
         2'h1: s_d.gate_out = dly_lvl[sbd_pkg::P_TGATE];
         2'h2: s_d.gate_out = dly_lvl[sbd_pkg::P_CGATE];
         2'h3: s_d.gate_out = ugate;
      endcase
      // outgoing differential sync source
      unique case (s_q.ctrl[sbd_pkg::CTRL_OSYNC_LSB +: 2])
         2'h0: s_d.sync_out = s_q.ctrl[sbd_pkg::CTRL_SW_SYNC];
         2'h1: s_d.sync_out = dly_lvl[sbd_pkg::P_TSYNC];
         2'h2: s_d.sync_out = gate_edge;
         2'h3: s_d.sync_out = usync;
      endcase
      // bus drivers follow the master control bit
      s_d.master = s_q.ctrl[sbd_pkg::CTRL_MASTER];
      if (!s_q.ctrl[sbd_pkg::CTRL_MASTER]) begin
         s_d.gate_out = 1'b0;
         s_d.sync_out = 1'b0;
      end

      // event sources use the delayed inputs
      unique case (s_q.ctrl[sbd_pkg::CTRL_EGATE_LSB +: 2])
         2'h0: s_d.evt_gate = s_q.ctrl[sbd_pkg::CTRL_SW_GATE];
         2'h1: s_d.evt_gate = dly_lvl[sbd_pkg::P_TGATE];
         2'h2: s_d.evt_gate = dly_lvl[sbd_pkg::P_CGATE];
         2'h3: s_d.evt_gate = dly_lvl[sbd_pkg::P_DGATE];
      endcase
      unique case (s_q.ctrl[sbd_pkg::CTRL_ESYNC_LSB +: 2])
         2'h0: s_d.evt_sync = s_q.ctrl[sbd_pkg::CTRL_SW_SYNC];
         2'h1: s_d.evt_sync = dly_lvl[sbd_pkg::P_TSYNC];
         2'h2: s_d.evt_sync = gate_edge;
         2'h3: s_d.evt_sync = dly_lvl[sbd_pkg::P_DSYNC];
      endcase
      unique case (s_q.ctrl[sbd_pkg::CTRL_EPPS_LSB +: 3])
         3'h0: s_d.evt_pps = s_q.ctrl[sbd_pkg::CTRL_SW_PPS];
         3'h1: s_d.evt_pps = dly_lvl[sbd_pkg::P_TSYNC];
         3'h2: s_d.evt_pps = gate_edge;
         3'h3: s_d.evt_pps = dly_lvl[sbd_pkg::P_DSYNC];
         3'h4: s_d.evt_pps = dly_lvl[sbd_pkg::P_TGATE];
         3'h5: s_d.evt_pps = dly_lvl[sbd_pkg::P_CGATE];
         3'h6: s_d.evt_pps = upps;
         3'h7: s_d.evt_pps = 1'b0;
      endcase
      s_d.gate_prev = s_q.evt_gate;

      // relay copies of the received single-ended inputs, undelayed
      s_d.gate_relay = relay_master_option && gate_relay_output_present
         && sync_lvl[sbd_pkg::P_TGATE];
      s_d.sync_relay = relay_master_option && sync_relay_output_present
         && sync_lvl[sbd_pkg::P_TSYNC];
      s_d.coax_relay = relay_master_option && coax_relay_output_present
         && sync_lvl[sbd_pkg::P_CGATE];
   end

   // one register for all state; tap values reload on every reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.ctrl <= sbd_pkg::CTRL_RESET;
         for (int p = 0; p < NP; p++) begin
            s_q.tap[p] <= TAP_INIT[p];
         end
      end else begin
         s_q <= s_d;
      end
   end

   // every output is a flop of the state
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign bus_master_en = s_q.master;
   assign diff_gate_out = s_q.gate_out;
   assign diff_sync_out = s_q.sync_out;
   assign gate_relay_out = s_q.gate_relay;
   assign sync_relay_out = s_q.sync_relay;
   assign coax_relay_out = s_q.coax_relay;
   assign dgate_tap = s_q.tap[sbd_pkg::P_DGATE];
   assign dsync_tap = s_q.tap[sbd_pkg::P_DSYNC];
   assign tgate_tap = s_q.tap[sbd_pkg::P_TGATE];
   assign tsync_tap = s_q.tap[sbd_pkg::P_TSYNC];
   assign cgate_tap = s_q.tap[sbd_pkg::P_CGATE];
   assign evt_gate = s_q.evt_gate;
   assign evt_sync = s_q.evt_sync;
   assign evt_pps = s_q.evt_pps;
endmodule // sbd_top

// ==== verification/sbd_top_sva.sv ====
// checker for sbd_top, bound from the bench top file
// assumes one aclk domain and a synchronous active-low aresetn
`timescale 1ns/100ps
module sbd_top_sva #(
   parameter logic [8:0] init_dgate_tap = 9'h000,
   parameter logic [8:0] init_cgate_tap = 9'h000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic bus_master_en,
   input wire logic diff_gate_out,
   input wire logic diff_sync_out,
   input wire logic coax_relay_out,
   input wire logic [8:0] dgate_tap,
   input wire logic [8:0] cgate_tap
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // write steps: both halves taken together, then a held cycle, then answer
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      ##1 !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
      s_axi_awready && !s_axi_bvalid && !s_axi_rvalid && dgate_tap == init_dgate_tap
      && cgate_tap == init_cgate_tap)
      else $error("state after reset wrong");
   a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
      else $error("write response not two edges after handshake");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one edge after address");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before rready");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr >= 6'h20 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_diff_gated: assert property (!bus_master_en |-> !diff_gate_out && !diff_sync_out)
      else $error("differential line driven without bus master");
   a_coax_relay_off: assert property (!coax_relay_out)
      else $error("coax relay driven with its option off");
endmodule // sbd_top_sva

// ==== verification/sbd_fp_model.sv ====
// front-panel bus model: drives the five received lines
// assumes the bench hands it wanted levels; lines lag by an unrelated skew
`timescale 1ns/100ps
module sbd_fp_model (
   input wire logic [4:0] lvl,
   output wire logic diff_gate_in,
   output wire logic diff_sync_in,
   output wire logic ttl_gate_in,
   output wire logic ttl_sync_in,
   output wire logic coax_gate_in
);
   // skew keeps edges away from aclk, as a real cable would
   assign #1.3 {coax_gate_in, ttl_sync_in, ttl_gate_in, diff_sync_in, diff_gate_in} = lvl;
endmodule // sbd_fp_model

// ==== verification/sbd_top_tb.sv ====
// self-checking bench for sbd_top with register rows and hand tests
// assumes a 250 MHz aclk; the front panel comes from sbd_fp_model
`timescale 1ns/100ps
module sbd_top_tb;
   typedef struct {logic wr; logic [5:0] a; logic [31:0] d; logic [31:0] x;
      logic [1:0] r;} sbd_row_t;
   localparam logic [8:0] DTAP = 9'h1FF;
   localparam logic [8:0] TTAP = 9'h0A5;
   localparam logic [1:0] DINT = 2'h3;
   localparam logic [1:0] TINT = 2'h0;
   localparam bit ON = 1'b1;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, pps, usync, ugate, master, dgo, dso, gro, sro, cro, eg, es, ep;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0] strb;
   logic [1:0] bresp, rresp, resp;
   logic [4:0] lvl;
   logic [8:0] t0, t1, t2, t3, t4;
   logic diw, dsw, tgw, tsw, cgw;
   int err_count, checks_done, nt, nd;
   sbd_row_t rows[8];
   sbd_top #(.relay_master_option(ON), .gate_relay_output_present(ON),
      .sync_relay_output_present(ON), .has_coax_gate_input(ON), .has_user_pps_input(ON),
      .has_user_sync_drive(ON), .has_user_gate_drive(ON), .init_dgate_tap(DTAP),
      .init_tgate_tap(TTAP), .init_dgate_int(DINT), .init_tgate_int(TINT)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .diff_gate_in(diw), .diff_sync_in(dsw), .ttl_gate_in(tgw), .ttl_sync_in(tsw),
      .coax_gate_in(cgw), .user_pps_in(pps), .user_sync_drive_in(usync),
      .user_gate_drive_in(ugate), .bus_master_en(master), .diff_gate_out(dgo),
      .diff_sync_out(dso), .gate_relay_out(gro), .sync_relay_out(sro), .coax_relay_out(cro),
      .dgate_tap(t0), .dsync_tap(t1), .tgate_tap(t2), .tsync_tap(t3), .cgate_tap(t4),
      .evt_gate(eg), .evt_sync(es), .evt_pps(ep));
   sbd_fp_model fp (.lvl(lvl), .diff_gate_in(diw), .diff_sync_in(dsw), .ttl_gate_in(tgw),
      .ttl_sync_in(tsw), .coax_gate_in(cgw));
   // clock, 4 ns period
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // count one comparison, report a mismatch at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d, checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // write: both halves offered together, each released when taken
   // bready rises late so the response must stand a cycle
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      strb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready) && n < 50);
      chk(n < 50, 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready) && n < 50);
      chk(n < 50, 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic ctrl(input logic [31:0] v);
      wr(sbd_pkg::OFS_CTRL, v, 4'hF, resp);
   endtask
   // cycles until the chosen output goes high, 40 at most
   task automatic lat(input int s, output int n);
      n = 0;
      while ((s == 0 ? eg : s == 1 ? dgo : ep) !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk(n < 40, 1'b1);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge aclk);
   endtask
   // cut a hang short
   initial begin
      #40000;
      err_count++;
      wrap_up();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, pps, usync, ugate} = '0;
      {awaddr, araddr, wdata, lvl, strb} = '0;
      err_count = 0;
      checks_done = 0;
      rows = '{'{0, 6'h04, 0, DTAP, 2'h0}, '{0, 6'h14, 0, 0, 2'h0}, '{0, 6'h0C, 0, TTAP, 2'h0},
         '{1, 6'h08, 32'hFFFF_FE5A, 0, 2'h0}, '{0, 6'h08, 0, 32'h0000_005A, 2'h0},
         '{1, 6'h20, 32'h0000_0001, 0, 2'h2}, '{0, 6'h20, 0, 0, 2'h2}, '{0, 6'h3C, 0, 0, 2'h2}};
      idle(4);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d, 4'hF, resp);
         else rd(rows[i].a, rdv, resp);
         chk(resp, rows[i].r);
         if (!rows[i].wr) chk(rdv, rows[i].x);
      end
      // byte lane 1 only: tap bit 8 set, low byte left at zero
      wr(sbd_pkg::OFS_TAP3, 32'hFFFF_FF55, 4'h2, resp);
      rd(sbd_pkg::OFS_TAP3, rdv, resp);
      chk(rdv, 32'h0000_0100);
      chk(t3, 9'h100);
      // whole-cycle delay seen as latency difference, ttl path then diff path
      ctrl(32'h0000_0100);
      lvl <= 5'b01100;
      lat(0, nt);
      chk({gro, sro}, 2'b11);
      lvl <= 5'b10000;
      idle(20);
      chk(cro, 1'b0);
      ctrl(32'h0000_0300);
      lvl <= 5'b10001;
      lat(0, nd);
      chk(nd - nt, DINT - TINT);
      ctrl(32'h0000_0200);
      lat(0, nd);
      // outgoing lines held off until bus master bit is set
      lvl <= 5'b10100;
      ctrl(32'h0000_0010);
      idle(10);
      chk({master, dgo}, 2'b00);
      ctrl(32'h0000_0011);
      lat(1, nd);
      chk(master, 1'b1);
      ctrl(32'h0000_60F5);
      ugate <= 1'b1;
      pps <= 1'b1;
      idle(4);
      chk({dgo, dso, ep, es}, 4'b1011);
      ugate <= 1'b0;
      usync <= 1'b1;
      idle(4);
      chk({dgo, dso}, 2'b01);
      // second reset mid-run restores the build values
      aresetn <= 1'b0;
      idle(4);
      aresetn <= 1'b1;
      idle(1);
      chk({t0, t2, t4, master, dgo}, {DTAP, TTAP, 9'h000, 2'b00});
      chk({t1, t3}, 18'h0_0000);
      rd(sbd_pkg::OFS_CTRL, rdv, resp);
      chk(rdv, 32'h0000_0000);
      wrap_up();
   end
endmodule // sbd_top_tb
bind sbd_top sbd_top_sva #(.init_dgate_tap(init_dgate_tap),
   .init_cgate_tap(init_cgate_tap)) chk_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .bus_master_en(bus_master_en), .diff_gate_out(diff_gate_out), .diff_sync_out(diff_sync_out),
   .coax_relay_out(coax_relay_out), .dgate_tap(dgate_tap), .cgate_tap(cgate_tap));
